// ---- hw/cim_top.sv ----
// Purpose: cascaded pair of interrupt controllers with mask and trigger registers
// Assumes: io_wr/io_rd are one-cycle strobes; inta is a one-cycle acknowledge
// Notes: read data and vector appear one cycle after their strobe
//
// Functional notes
// (RL1) software writes init_word_four to both controllers during initialization
// (RL2) init_word_four bit 0 is processor mode; vectors returned only when set
// (RL3) software writes init_word_four bits 7..5 as zero
// (RL4) software keeps special nested option bit 4 at zero
// (RL5) software keeps buffered bits 3 and 2 at zero
// (RL6) init_word_four bit 1 set enables automatic end of interrupt
// (RL7) a 1 written to a mask bit blocks that request line
// (RL8) a 0 written to a mask bit accepts that request line again
// (RL9) each mask bit changes independently after init; mask is readable
// (RL10) masking master line 2 blocks all slave requests
// (RL11) trigger-select bit 0 makes its channel edge sensitive
// (RL12) both trigger-select registers reset to zero
// (RL13) software keeps master trigger bits 0..2 at zero
// (RL14) software keeps slave trigger bits 5 and 0 at zero
// (RL15) master trigger at 4d0h is channel n, slave at 4d1h is n+8
// (RL16) trigger-select bit 1 makes its channel level sensitive
// (RL17) acknowledge vector low three bits carry the serviced line number
// (RL18) slave interrupt output drives master request line 2
`timescale 1ns/10ps
`default_nettype none
module cim_top
	import cim_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic [15:0] irq_line,
	input wire logic inta,
	output logic int_req,
	output logic [7:0] inta_vector,
	output logic inta_valid
);
	typedef struct packed {
		logic [7:0] trig_m;
		logic [7:0] trig_s;
		logic [7:0] rdata;
		logic [7:0] vector;
		logic valid;
	} cim_top_state_t;

	cim_top_state_t st;
	cim_top_state_t next_st;
	logic m_int;
	logic s_int;
	logic [2:0] m_sel;
	logic [2:0] s_sel;
	logic [4:0] m_base;
	logic [4:0] s_base;
	logic [7:0] m_mask;
	logic [7:0] s_mask;
	logic m_proc;
	logic s_proc;
	logic m_irq_in_2;
	logic m_cmd_wr;
	logic m_data_wr;
	logic s_cmd_wr;
	logic s_data_wr;
	logic via_slave;
	logic s_ack;

	// port decode for the two controllers
	assign m_cmd_wr = io_wr && io_addr == CIM_MASTER_CMD;
	assign m_data_wr = io_wr && io_addr == CIM_MASTER_DATA;
	assign s_cmd_wr = io_wr && io_addr == CIM_SLAVE_CMD;
	assign s_data_wr = io_wr && io_addr == CIM_SLAVE_DATA;

	// slave output feeds master line 2, so its mask gates the slave too
	assign m_irq_in_2 = s_int; // see (RL18) see (RL10)
	assign via_slave = m_sel == CIM_CASCADE_LINE;
	assign s_ack = inta && m_int && via_slave;
	assign int_req = m_int;

	cim_unit #(
		.LINES(CIM_LINES)
	) u_master (
		.clk(clk),
		.rst_n(rst_n),
		.cmd_wr(m_cmd_wr),
		.data_wr(m_data_wr),
		.wdata(io_wdata),
		.irq_in({irq_line[7:3], m_irq_in_2, irq_line[1:0]}),
		.trig_level(st.trig_m), // see (RL15)
		.ack(inta),
		.int_out(m_int),
		.sel_line(m_sel),
		.vec_base(m_base),
		.mask_bits(m_mask),
		.proc_mode(m_proc)
	);

	cim_unit #(
		.LINES(CIM_LINES)
	) u_slave (
		.clk(clk),
		.rst_n(rst_n),
		.cmd_wr(s_cmd_wr),
		.data_wr(s_data_wr),
		.wdata(io_wdata),
		.irq_in(irq_line[15:8]),
		.trig_level(st.trig_s), // see (RL15)
		.ack(s_ack),
		.int_out(s_int),
		.sel_line(s_sel),
		.vec_base(s_base),
		.mask_bits(s_mask),
		.proc_mode(s_proc)
	);

	// register writes, read mux and acknowledge vector
	always_comb
	begin
		next_st = st;
		next_st.valid = 1'b0;
		if (io_wr && io_addr == CIM_TRIG_MASTER)
			next_st.trig_m = io_wdata; // see (RL15)
		if (io_wr && io_addr == CIM_TRIG_SLAVE)
			next_st.trig_s = io_wdata; // see (RL15)
		if (io_rd)
		begin
			unique case (io_addr)
				CIM_MASTER_DATA: next_st.rdata = m_mask; // see (RL9)
				CIM_SLAVE_DATA: next_st.rdata = s_mask; // see (RL9)
				CIM_TRIG_MASTER: next_st.rdata = st.trig_m;
				CIM_TRIG_SLAVE: next_st.rdata = st.trig_s;
				default: next_st.rdata = CIM_UNMAPPED_READ;
			endcase
		end
		// only processor-mode vector format is supported
		if (inta && m_int && m_proc)
		begin
			next_st.valid = !via_slave || s_proc; // see (RL2)
			if (via_slave)
				next_st.vector = {s_base, s_sel}; // see (RL17)
			else
				next_st.vector = {m_base, m_sel}; // see (RL17)
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.trig_m <= CIM_TRIG_RESET; // see (RL12)
			st.trig_s <= CIM_TRIG_RESET; // see (RL12)
			st.rdata <= CIM_UNMAPPED_READ;
			st.vector <= 8'h00;
			st.valid <= 1'b0;
		end
		else
			st <= next_st;
	end

	assign io_rdata = st.rdata;
	assign inta_vector = st.vector;
	assign inta_valid = st.valid;

	property p_trig_write;
		@(posedge clk) disable iff (!rst_n)
		io_wr && io_addr == CIM_TRIG_SLAVE |=> st.trig_s == $past(io_wdata);
	endproperty
	a_trig_write: assert property (p_trig_write) else $error("slave trigger lost"); // see (RL15)

	property p_trig_hold;
		@(posedge clk) disable iff (!rst_n)
		!(io_wr && io_addr == CIM_TRIG_MASTER) |=> $stable(st.trig_m);
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("master trigger changed"); // see (RL12)

	property p_cascade_block;
		@(posedge clk) disable iff (!rst_n)
		m_mask[2] |-> !(m_int && via_slave);
	endproperty
	a_cascade_block: assert property (p_cascade_block) else $error("slave passed mask"); // see (RL10)

	sequence s_master_ack;
		inta && m_int && m_proc && !via_slave;
	endsequence
	property p_master_vector;
		@(posedge clk) disable iff (!rst_n)
		s_master_ack |=> inta_valid && inta_vector == {$past(m_base), $past(m_sel)};
	endproperty
	a_master_vector: assert property (p_master_vector) else $error("bad master vector"); // see (RL17)

	sequence s_slave_ack;
		inta && m_int && m_proc && via_slave && s_proc;
	endsequence
	property p_slave_vector;
		@(posedge clk) disable iff (!rst_n)
		s_slave_ack |=> inta_valid && inta_vector[2:0] == $past(s_sel);
	endproperty
	a_slave_vector: assert property (p_slave_vector) else $error("bad slave vector"); // see (RL17)

	property p_proc_mode;
		@(posedge clk) disable iff (!rst_n)
		inta && !m_proc |=> !inta_valid;
	endproperty
	a_proc_mode: assert property (p_proc_mode) else $error("vector without proc mode"); // see (RL2)

	// one read strobe per register; the answer is looked at on the following edge
	sequence s_rd_mask_m;
		io_rd && io_addr == CIM_MASTER_DATA;
	endsequence
	sequence s_rd_mask_s;
		io_rd && io_addr == CIM_SLAVE_DATA;
	endsequence
	sequence s_rd_trig_m;
		io_rd && io_addr == CIM_TRIG_MASTER;
	endsequence
	sequence s_rd_trig_s;
		io_rd && io_addr == CIM_TRIG_SLAVE;
	endsequence
	sequence s_rd_other;
		io_rd && io_addr != CIM_MASTER_DATA && io_addr != CIM_SLAVE_DATA
			&& io_addr != CIM_TRIG_MASTER && io_addr != CIM_TRIG_SLAVE;
	endsequence

	// master trigger write lands on the next edge
	property p_trig_write_m;
		@(posedge clk) disable iff (!rst_n)
		io_wr && io_addr == CIM_TRIG_MASTER |=> st.trig_m == $past(io_wdata);
	endproperty
	a_trig_write_m: assert property (p_trig_write_m) else $error("master trigger lost"); // see (RL15)

	// slave trigger only changes on its own write
	property p_trig_hold_s;
		@(posedge clk) disable iff (!rst_n)
		!(io_wr && io_addr == CIM_TRIG_SLAVE) |=> $stable(st.trig_s);
	endproperty
	a_trig_hold_s: assert property (p_trig_hold_s) else $error("slave trigger changed"); // see (RL12)

	// mask reads return the live mask of each controller
	property p_read_mask_m;
		@(posedge clk) disable iff (!rst_n)
		s_rd_mask_m |=> io_rdata == $past(m_mask);
	endproperty
	a_read_mask_m: assert property (p_read_mask_m) else $error("master mask read wrong"); // see (RL9)

	property p_read_mask_s;
		@(posedge clk) disable iff (!rst_n)
		s_rd_mask_s |=> io_rdata == $past(s_mask);
	endproperty
	a_read_mask_s: assert property (p_read_mask_s) else $error("slave mask read wrong"); // see (RL9)

	// trigger reads return the register of the addressed controller
	property p_read_trig_m;
		@(posedge clk) disable iff (!rst_n)
		s_rd_trig_m |=> io_rdata == $past(st.trig_m);
	endproperty
	a_read_trig_m: assert property (p_read_trig_m) else $error("master trigger read wrong"); // see (RL15)

	property p_read_trig_s;
		@(posedge clk) disable iff (!rst_n)
		s_rd_trig_s |=> io_rdata == $past(st.trig_s);
	endproperty
	a_read_trig_s: assert property (p_read_trig_s) else $error("slave trigger read wrong"); // see (RL15)

	// unmapped ports read as zero, so no stale byte leaks out
	property p_read_other;
		@(posedge clk) disable iff (!rst_n)
		s_rd_other |=> io_rdata == CIM_UNMAPPED_READ;
	endproperty
	a_read_other: assert property (p_read_other) else $error("unmapped read not zero"); // see (RL15)

	// read data stands until the next read strobe
	property p_read_hold;
		@(posedge clk) disable iff (!rst_n)
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved"); // see (RL9)

	// a vector is flagged only for an acknowledge strobe
	property p_valid_needs_ack;
		@(posedge clk) disable iff (!rst_n)
		!inta |=> !inta_valid;
	endproperty
	a_valid_needs_ack: assert property (p_valid_needs_ack) else $error("valid without ack"); // see (RL17)

	// an acknowledge with nothing pending is refused
	property p_ack_refused;
		@(posedge clk) disable iff (!rst_n)
		inta && !m_int |=> !inta_valid;
	endproperty
	a_ack_refused: assert property (p_ack_refused) else $error("idle ack gave a vector"); // see (RL17)

	// the vector stands until the next accepted acknowledge
	property p_vector_hold;
		@(posedge clk) disable iff (!rst_n)
		!(inta && m_int && m_proc) |=> $stable(inta_vector);
	endproperty
	a_vector_hold: assert property (p_vector_hold) else $error("vector moved"); // see (RL17)

	// a slave vector carries the slave base above the line number
	property p_slave_base;
		@(posedge clk) disable iff (!rst_n)
		s_slave_ack |=> inta_vector[7:3] == $past(s_base);
	endproperty
	a_slave_base: assert property (p_slave_base) else $error("bad slave base"); // see (RL17)

	// a raised request never names a masked line
	property p_master_unmasked;
		@(posedge clk) disable iff (!rst_n)
		m_int |-> !m_mask[m_sel];
	endproperty
	a_master_unmasked: assert property (p_master_unmasked) else $error("masked master line"); // see (RL7)

	property p_slave_unmasked;
		@(posedge clk) disable iff (!rst_n)
		s_int |-> !s_mask[s_sel];
	endproperty
	a_slave_unmasked: assert property (p_slave_unmasked) else $error("masked slave line"); // see (RL7)
endmodule
`default_nettype wire

// ---- hw/cim_pkg.sv ----
// Purpose: shared constants for the cascaded interrupt mask/trigger block
// Assumes: 16-bit I/O address space, 8-bit I/O data
// Notes: each controller has an even command port and an odd data port
package cim_pkg;
	localparam int unsigned CIM_LINES = 8;
	// I/O port map
	localparam logic [15:0] CIM_MASTER_CMD = 16'h0020;
	localparam logic [15:0] CIM_MASTER_DATA = 16'h0021;
	localparam logic [15:0] CIM_SLAVE_CMD = 16'h00a0;
	localparam logic [15:0] CIM_SLAVE_DATA = 16'h00a1;
	localparam logic [15:0] CIM_TRIG_MASTER = 16'h04d0;
	localparam logic [15:0] CIM_TRIG_SLAVE = 16'h04d1;
	// reset values
	localparam logic [7:0] CIM_TRIG_RESET = 8'h00;
	localparam logic [7:0] CIM_MASK_RESET = 8'hff;
	localparam logic [7:0] CIM_UNMAPPED_READ = 8'h00;
	// command-port field positions
	localparam int unsigned CIM_CMD_INIT_BIT = 4;
	localparam int unsigned CIM_CMD_MODE_SEL_BIT = 3;
	localparam int unsigned CIM_CMD_EOI_BIT = 5;
	localparam int unsigned CIM_CMD_SPEC_BIT = 6;
	// init_word_four field positions
	localparam int unsigned CIM_W4_PROC_MODE = 0;
	localparam int unsigned CIM_W4_AUTO_EOI = 1;
	localparam int unsigned CIM_W4_MASTER_SLAVE = 2;
	localparam int unsigned CIM_W4_BUFFERED = 3;
	localparam int unsigned CIM_W4_SPECIAL_NESTED = 4;
	localparam logic [2:0] CIM_CASCADE_LINE = 3'h2;
	// initialization sequence steps, one-hot
	typedef enum logic [3:0] {
		CIM_ST_READY = 4'b0001,
		CIM_ST_VECTOR = 4'b0010,
		CIM_ST_CASCADE = 4'b0100,
		CIM_ST_WORD4 = 4'b1000
	} cim_step_t;
endpackage

// ---- hw/cim_unit.sv ----
// Purpose: one 8-input interrupt controller: init words, mask, request, in-service
// Assumes: inputs synchronous to clk; line 0 has the highest priority
// Notes: the second to fourth init words are taken and the third is ignored
`timescale 1ns/10ps
`default_nettype none
module cim_unit
	import cim_pkg::*;
#(
	parameter int unsigned LINES = CIM_LINES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_wr,
	input wire logic data_wr,
	input wire logic [7:0] wdata,
	input wire logic [LINES-1:0] irq_in,
	input wire logic [LINES-1:0] trig_level,
	input wire logic ack,
	output logic int_out,
	output logic [2:0] sel_line,
	output logic [4:0] vec_base,
	output logic [LINES-1:0] mask_bits,
	output logic proc_mode
);
	typedef struct packed {
		cim_step_t step;
		logic init_done;
		logic [4:0] base;
		logic [7:0] word4;
		logic [LINES-1:0] mask;
		logic [LINES-1:0] irr;
		logic [LINES-1:0] isr;
		logic [LINES-1:0] prev_in;
	} cim_unit_state_t;

	cim_unit_state_t st;
	cim_unit_state_t next_st;
	logic [LINES-1:0] req;
	logic eligible;
	logic [2:0] req_idx;
	logic req_any;
	logic [2:0] isr_idx;
	logic isr_any;
	logic auto_eoi;

	// lowest-numbered active request and in-service line
	always_comb
	begin
		req = st.irr & ~st.mask;
		req_idx = 3'h0;
		req_any = 1'b0;
		isr_idx = 3'h0;
		isr_any = 1'b0;
		for (int i = LINES - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				req_idx = 3'(i);
				req_any = 1'b1;
			end
			if (st.isr[i])
			begin
				isr_idx = 3'(i);
				isr_any = 1'b1;
			end
		end
		// a request only interrupts a line of lower priority in service
		eligible = st.init_done && req_any && (!isr_any || req_idx < isr_idx);
	end

	assign int_out = eligible;
	assign sel_line = req_idx; // see (RL17)
	assign vec_base = st.base;
	assign mask_bits = st.mask; // see (RL9)
	assign proc_mode = st.word4[CIM_W4_PROC_MODE]; // see (RL2)
	assign auto_eoi = st.word4[CIM_W4_AUTO_EOI];

	// next state: request capture, ack, end of interrupt, init sequence
	always_comb
	begin
		next_st = st;
		next_st.prev_in = irq_in;
		for (int i = 0; i < LINES; i++)
		begin
			if (trig_level[i])
				next_st.irr[i] = irq_in[i]; // see (RL16)
			else if (irq_in[i] && !st.prev_in[i])
				next_st.irr[i] = 1'b1; // see (RL11)
		end
		// end of interrupt goes first, so an acknowledge in the same cycle wins
		if (cmd_wr && !wdata[CIM_CMD_INIT_BIT] && !wdata[CIM_CMD_MODE_SEL_BIT]
			&& wdata[CIM_CMD_EOI_BIT])
		begin
			if (wdata[CIM_CMD_SPEC_BIT])
				next_st.isr[wdata[2:0]] = 1'b0;
			else if (isr_any)
				next_st.isr[isr_idx] = 1'b0;
		end
		if (ack && eligible)
		begin
			// edge requests are consumed unless a fresh edge lands in the same cycle
			if (!trig_level[req_idx] && !(irq_in[req_idx] && !st.prev_in[req_idx]))
				next_st.irr[req_idx] = 1'b0;
			if (!auto_eoi)
				next_st.isr[req_idx] = 1'b1; // see (RL6)
		end
		// init restarts the sequence and drops everything pending
		if (cmd_wr && wdata[CIM_CMD_INIT_BIT])
		begin
			next_st.step = CIM_ST_VECTOR;
			next_st.init_done = 1'b0;
			next_st.irr = '0;
			next_st.isr = '0;
		end
		if (data_wr)
		begin
			unique case (st.step)
				CIM_ST_VECTOR:
				begin
					next_st.base = wdata[7:3];
					next_st.step = CIM_ST_CASCADE;
				end
				CIM_ST_CASCADE:
					next_st.step = CIM_ST_WORD4;
				CIM_ST_WORD4:
				begin
					next_st.word4 = wdata; // see (RL6)
					next_st.init_done = 1'b1;
					next_st.step = CIM_ST_READY;
				end
				CIM_ST_READY:
					next_st.mask = wdata[LINES-1:0]; // see (RL7) see (RL8)
				default:
					next_st.step = CIM_ST_READY;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.step <= CIM_ST_READY;
			st.init_done <= 1'b0;
			st.base <= 5'h00;
			st.word4 <= 8'h00;
			st.mask <= CIM_MASK_RESET[LINES-1:0];
			st.irr <= '0;
			st.isr <= '0;
			st.prev_in <= '0;
		end
		else
			st <= next_st;
	end

	// mask write in ready state lands exactly
	property p_mask_write;
		@(posedge clk) disable iff (!rst_n)
		data_wr && st.step == CIM_ST_READY |=> st.mask == $past(wdata[LINES-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask not updated"); // see (RL7)

	sequence s_ack_taken;
		ack && eligible;
	endsequence
	// auto end of interrupt leaves nothing in service
	property p_auto_eoi;
		@(posedge clk) disable iff (!rst_n)
		s_ack_taken and (auto_eoi && !cmd_wr) ##0 (st.isr == '0) |=> st.isr == '0;
	endproperty
	a_auto_eoi: assert property (p_auto_eoi) else $error("isr set under auto eoi"); // see (RL6)

	// level lines follow the pin when no init write intervenes
	property p_level_follow;
		@(posedge clk) disable iff (!rst_n)
		!cmd_wr |=> (st.irr & $past(trig_level)) == ($past(irq_in) & $past(trig_level));
	endproperty
	a_level_follow: assert property (p_level_follow) else $error("level request lost"); // see (RL16)

	// a steady high edge line makes no new request
	property p_edge_hold;
		@(posedge clk) disable iff (!rst_n)
		!cmd_wr |=> (st.irr & ~$past(st.irr) & ~$past(trig_level) & $past(st.prev_in)) == '0;
	endproperty
	a_edge_hold: assert property (p_edge_hold) else $error("edge line retriggered"); // see (RL11)
endmodule
`default_nettype wire

// ---- verif/cim_host.sv ----
// Purpose: host model issuing I/O cycles and interrupt acknowledges
// Assumes: one-cycle strobes; read data and vector land one cycle later
// Notes: address and data are inverted on release so stale values never match
`timescale 1ns/10ps
`default_nettype none
module cim_host
(
	input wire logic clk,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	output logic inta,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] inta_vector,
	input wire logic inta_valid
);
	// idle bus at time zero
	initial
	begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
		inta = 1'b0;
	end

	// one I/O cycle; the strobe is taken at the second edge
	task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= w;
		io_rd <= ~w;
		@(posedge clk);
		io_wr <= 1'b0;
		io_rd <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~d;
	endtask

	// one-cycle acknowledge pulse
	task automatic ack();
		@(posedge clk);
		inta <= 1'b1;
		@(posedge clk);
		inta <= 1'b0;
	endtask

	// full init sequence; word four keeps reserved, nested and buffer bits clear
	task automatic init(input logic [15:0] cmd, input logic [7:0] base, input logic [7:0] casc,
		input logic auto_eoi_on);
		cyc(cmd, 8'h11, 1'b1);
		cyc(cmd + 16'h0001, base, 1'b1);
		cyc(cmd + 16'h0001, casc, 1'b1);
		cyc(cmd + 16'h0001, {6'h00, auto_eoi_on, 1'b1}, 1'b1);
	endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the cascaded mask and trigger block
// Assumes: host model drives the I/O bus; bench drives request lines
// Notes: master base 08h, slave base 70h; master line 5 is level sensitive
`timescale 1ns/10ps
`default_nettype none
module testbench
	import cim_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] irq_line = 16'h0000;
	logic [15:0] io_addr;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic inta;
	logic int_req;
	logic [7:0] inta_vector;
	logic inta_valid;
	int failures = 0;
	int num_checks = 0;

	cim_top cim_top_inst (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_line(irq_line),
		.inta(inta), .int_req(int_req), .inta_vector(inta_vector), .inta_valid(inta_valid));
	cim_host cim_host_inst (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .inta(inta), .io_rdata(io_rdata), .inta_vector(inta_vector),
		.inta_valid(inta_valid));

	// 100 MHz
	always #5 clk = ~clk;

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// let n edges pass, then look after their updates settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cim_host_inst.cyc(a, d, 1'b1);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		cim_host_inst.cyc(a, 8'h00, 1'b0);
		#1;
		chk("io_rdata", e, io_rdata);
	endtask

	task automatic irq(input int i, input logic v);
		@(posedge clk);
		irq_line[i] <= v;
	endtask

	task automatic ack_exp(input logic [7:0] e);
		cim_host_inst.ack();
		#1;
		chk1("inta_valid", 1'b1, inta_valid);
		chk("inta_vector", e, inta_vector);
		tick(1);
		chk1("inta_valid", 1'b0, inta_valid);
	endtask

	// an acknowledge with nothing pending must not flag a vector
	task automatic ack_none();
		cim_host_inst.ack();
		#1;
		chk1("inta_valid", 1'b0, inta_valid);
	endtask

	task automatic t_reset();
		rd(CIM_TRIG_MASTER, CIM_TRIG_RESET);
		rd(CIM_TRIG_SLAVE, CIM_TRIG_RESET);
		rd(CIM_MASTER_DATA, CIM_MASK_RESET);
		rd(16'h0300, CIM_UNMAPPED_READ);
		chk1("int_req", 1'b0, int_req);
	endtask

	// a second reset mid-run brings the written trigger registers back
	task automatic t_reset_again();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk1("int_req", 1'b0, int_req);
		ack_none();
		rd(CIM_TRIG_MASTER, CIM_TRIG_RESET);
		rd(CIM_TRIG_SLAVE, CIM_TRIG_RESET);
		rd(CIM_MASTER_DATA, CIM_MASK_RESET);
	endtask

	// channels that must stay edge keep their bits clear
	task automatic t_trig();
		wr(CIM_TRIG_MASTER, 8'h20);
		wr(CIM_TRIG_SLAVE, 8'hd6);
		rd(CIM_TRIG_MASTER, 8'h20);
		rd(CIM_TRIG_SLAVE, 8'hd6);
	endtask

	task automatic t_init();
		cim_host_inst.init(CIM_MASTER_CMD, 8'h08, 8'h04, 1'b0);
		cim_host_inst.init(CIM_SLAVE_CMD, 8'h70, 8'h02, 1'b0);
		wr(CIM_MASTER_DATA, 8'h9b);
		wr(CIM_SLAVE_DATA, 8'hf7);
		rd(CIM_MASTER_DATA, 8'h9b);
		rd(CIM_SLAVE_DATA, 8'hf7);
	endtask

	// edge line 6: cleared by ack although the pin stays high
	task automatic t_edge_mask();
		irq(6, 1'b1);
		tick(3);
		chk1("int_req", 1'b1, int_req);
		ack_exp(8'h0e);
		wr(CIM_MASTER_CMD, 8'h20);
		tick(2);
		chk1("int_req", 1'b0, int_req);
		irq(6, 1'b0);
		wr(CIM_MASTER_DATA, 8'hdb);
		irq(6, 1'b1);
		tick(3);
		chk1("int_req", 1'b0, int_req);
		irq(6, 1'b0);
	endtask

	// level line 5 asks again after end of interrupt while held
	task automatic t_level();
		irq(5, 1'b1);
		tick(3);
		chk1("int_req", 1'b1, int_req);
		ack_exp(8'h0d);
		wr(CIM_MASTER_CMD, 8'h65); // specific end of interrupt for line 5
		tick(2);
		chk1("int_req", 1'b1, int_req);
		ack_exp(8'h0d);
		irq(5, 1'b0);
		wr(CIM_MASTER_CMD, 8'h20);
		tick(2);
		chk1("int_req", 1'b0, int_req);
	endtask

	// slave line 11 reaches the host through master line 2
	task automatic t_slave();
		irq(11, 1'b1);
		tick(4);
		chk1("int_req", 1'b1, int_req);
		ack_exp(8'h73);
		irq(11, 1'b0);
		wr(CIM_SLAVE_CMD, 8'h20);
		wr(CIM_MASTER_CMD, 8'h20);
		wr(CIM_MASTER_DATA, 8'hdf);
		irq(11, 1'b1);
		tick(4);
		chk1("int_req", 1'b0, int_req);
		irq(11, 1'b0);
	endtask

	// auto end of interrupt lets lower line 7 in without a command
	task automatic t_auto_end_of_irq();
		cim_host_inst.init(CIM_MASTER_CMD, 8'h08, 8'h04, 1'b1);
		wr(CIM_MASTER_DATA, 8'h3f);
		irq(6, 1'b1);
		tick(3);
		ack_exp(8'h0e);
		irq(7, 1'b1);
		tick(3);
		chk1("int_req", 1'b1, int_req);
		ack_exp(8'h0f);
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		t_reset();
		t_trig();
		t_init();
		t_edge_mask();
		t_level();
		t_slave();
		t_auto_end_of_irq();
		t_reset_again();
		end_of_test();
	end

	// whole run is under two hundred cycles
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
